// [common/pmc_pkg.sv]
/*
 * Package of the T1/J1 performance monitor counter block: register indices,
 * field positions, counter limits, link event carriers and the state record.
 * Assumes one 10 MHz system clock shared with the framers that feed events.
 */
`default_nettype none
package pmc_pkg;
   localparam int NUM_LINKS = 4;
   // Printed offsets are word indices; byte address is four times the index
   localparam logic [9:0] IDX_ACCESS_SELECT = 10'h00E;
   localparam logic [9:0] IDX_ACCESS_READBACK = 10'h00F;
   localparam logic [7:0] IDX_UPDATE_CONTROL = 8'hC2;
   localparam logic [7:0] IDX_IRQ_ENABLE_LOW = 8'hC3;
   localparam logic [7:0] IDX_IRQ_ENABLE_HIGH = 8'hC4;
   localparam logic [7:0] IDX_FLAGS_LOW = 8'hC5;
   localparam logic [7:0] IDX_FLAGS_HIGH = 8'hC6;
   // Select register fields
   localparam int SEL_CNT_LSB = 0;
   localparam int SEL_LINK_LSB = 4;
   // Update control fields
   localparam int CTRL_MANUAL_BIT = 0;
   localparam int CTRL_AUTO_BIT = 1;
   // Overflow bit positions; bit 6 is bit 0 of the high register
   localparam int OVF_DDS = 0;
   localparam int OVF_CRC6 = 1;
   localparam int OVF_PATTERN = 2;
   localparam int OVF_SYNC_LOSS = 3;
   localparam int OVF_POSITION = 4;
   localparam int OVF_FRAMING = 5;
   localparam int OVF_LINE_CODE = 6;
   localparam int NUM_OVF = 7;
   // Counter selection codes
   localparam logic [3:0] SEL_CRC6_LO = 4'h0;
   localparam logic [3:0] SEL_CRC6_HI = 4'h1;
   localparam logic [3:0] SEL_FRAMING_LO = 4'h2;
   localparam logic [3:0] SEL_FRAMING_HI = 4'h3;
   localparam logic [3:0] SEL_POSITION = 4'h4;
   localparam logic [3:0] SEL_SYNC_LOSS = 4'h5;
   localparam logic [3:0] SEL_PATTERN_LO = 4'h6;
   localparam logic [3:0] SEL_PATTERN_HI = 4'h7;
   localparam logic [3:0] SEL_LINE_CODE_LO = 4'h8;
   localparam logic [3:0] SEL_LINE_CODE_HI = 4'h9;
   localparam logic [3:0] SEL_DDS_LO = 4'hA;
   localparam logic [3:0] SEL_DDS_HI = 4'hB;
   // Counter ceilings
   localparam logic [15:0] LINE_CODE_MAX = 16'hFFFF;
   localparam logic [15:0] FRAMING_MAX = 16'h0FFF;
   localparam logic [15:0] CRC6_MAX = 16'h03FF;
   localparam logic [15:0] DDS_MAX = 16'h03FF;
   localparam logic [15:0] POSITION_MAX = 16'h0007;
   localparam logic [15:0] SYNC_LOSS_MAX = 16'h001F;
   localparam logic [15:0] PATTERN_MAX = 16'hFFFF;
   // One-second tick
   localparam longint SECOND_NS = 1000000000;
   localparam longint CLK_PERIOD_NS = 100;
   localparam int SECOND_CYCLES = int'(SECOND_NS / CLK_PERIOD_NS);
   localparam logic [7:0] RESET_BYTE = 8'h00;

   typedef enum logic [1:0] {
      PMC_FMT_SF,
      PMC_FMT_ESF,
      PMC_FMT_DM,
      PMC_FMT_SLC96
   } pmc_format_e;

   typedef struct packed {
      pmc_format_e format;
      logic j1_mode;
   } pmc_link_cfg_s;

   // One-cycle event pulses from framer, decoder and pattern receiver
   typedef struct packed {
      logic line_code;
      logic framing;
      logic crc6;
      logic dds;
      logic position;
      logic sync_loss;
      logic pattern;
   } pmc_event_s;

   typedef struct packed {
      logic [15:0] line_code_violation_count;
      logic [11:0] framing_error_count;
      logic [9:0] crc6_error_count;
      logic [9:0] dds_pattern_error_count;
      logic [2:0] frame_position_change_count;
      logic [4:0] sync_loss_count;
      logic [15:0] pattern_receiver_error_count;
   } pmc_counters_s;

   typedef struct packed {
      pmc_counters_s [NUM_LINKS-1:0] cnt;
      logic [NUM_LINKS-1:0][NUM_OVF-1:0] ovf_flags;
      logic [NUM_LINKS-1:0][NUM_OVF-1:0] ovf_irq_on;
      logic [NUM_LINKS-1:0] manual_transfer_bit;
      logic [NUM_LINKS-1:0] auto_transfer_bit;
      logic [1:0] link_choice;
      logic [3:0] cnt_choice;
      logic [7:0] readback;
      logic [7:0] prdata;
      logic err;
      logic ready;
      logic [23:0] sec_cnt;
   } pmc_state_s;
endpackage
`default_nettype wire

// [testbench/pmc_event_source.sv]
/* Model of the framer, decoder and pattern receiver event sources.
   Assumes it is clocked by the monitor clock. */
`default_nettype none
module pmc_event_source (
   input wire logic clk_i,
   output pmc_pkg::pmc_event_s [pmc_pkg::NUM_LINKS-1:0] events_o
);
   import pmc_pkg::*;
   logic [NUM_LINKS-1:0][6:0] ev = '0;
   assign events_o = ev;
   // Consecutive cycles high, one event each
   task automatic fire(input int link, input int bit_no, input int n);
      repeat (n) begin
         @(posedge clk_i);
         ev[link][bit_no] <= 1'b1;
      end
      @(posedge clk_i);
      ev[link][bit_no] <= 1'b0;
   endtask
endmodule
`default_nettype wire

// [testbench/pmc_perf_monitor_properties.sv]
/* Checker of APB timing, decode and interrupt causes at the monitor ports.
   Assumes it is bound to pmc_perf_monitor on one clock. */
`default_nettype none
module pmc_perf_monitor_properties (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire pmc_pkg::pmc_event_s [pmc_pkg::NUM_LINKS-1:0] events_i,
   input wire logic irq_o
);
   import pmc_pkg::*;
   wire logic [7:0] low_idx = paddr_i[9:2];
   wire logic mapped = (paddr_i[11:2] == IDX_ACCESS_SELECT)
      || (paddr_i[11:2] == IDX_ACCESS_READBACK)
      || (low_idx >= IDX_UPDATE_CONTROL && low_idx <= IDX_FLAGS_HIGH);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   AST_READY_PULSE: assert property (pready_o |=> !pready_o)
      else $error("ready longer than one cycle");
   AST_READY_AFTER_ACCESS: assert property (psel_i && $rose(penable_i) |=> pready_o)
      else $error("no answer one cycle into access");
   AST_READY_CAUSE: assert property (pready_o |-> psel_i && penable_i && $past(penable_i))
      else $error("ready outside a two-cycle access");
   AST_ERR_WITH_READY: assert property (pslverr_o |-> pready_o)
      else $error("error without ready");
   AST_DECODE: assert property (pready_o |-> (pslverr_o == !mapped))
      else $error("error flag disagrees with decode");
   AST_RDATA_HIGH: assert property (prdata_o[31:8] == 24'h000000)
      else $error("read data upper bits set");
   AST_RDATA_HOLD: assert property (!pready_o |-> $stable(prdata_o))
      else $error("read data moved outside an answer");
   AST_IRQ_FALL: assert property ($fell(irq_o) |-> $past(pready_o && pwrite_i))
      else $error("interrupt dropped without a write");
   AST_IRQ_RISE: assert property ($rose(irq_o) |-> $past(pready_o && pwrite_i)
      || $past(|events_i))
      else $error("interrupt raised without cause");
endmodule
bind pmc_perf_monitor pmc_perf_monitor_properties u_props (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .events_i(events_i), .irq_o(irq_o));
`default_nettype wire

// [testbench/pmc_perf_monitor_tb.sv]
/* Self-checking bench of the performance monitor over APB.
   Assumes a one-second divider shortened to 20 cycles. */
`default_nettype none
module pmc_perf_monitor_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import pmc_pkg::*;
   localparam int SEC = 20;
   logic clk_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h00000000;
   logic [31:0] prdata_o;
   logic pready_o, pslverr_o, irq_o, err;
   logic [7:0] rd;
   pmc_event_s [NUM_LINKS-1:0] events_i;
   pmc_link_cfg_s [NUM_LINKS-1:0] cfg = '0;
   int error_cnt = 0;
   int samples_checked = 0;
   logic [3:0] codes [7] = '{SEL_CRC6_LO, SEL_FRAMING_LO, SEL_POSITION, SEL_SYNC_LOSS,
      SEL_PATTERN_LO, SEL_LINE_CODE_LO, SEL_DDS_LO};
   logic [3:0] hcodes [5] = '{SEL_CRC6_HI, SEL_FRAMING_HI, SEL_PATTERN_HI,
      SEL_LINE_CODE_HI, SEL_DDS_HI};
   int bits [7] = '{4, 5, 2, 1, 0, 6, 3};
   int hbits [5] = '{4, 5, 0, 6, 3};
   always #50 clk_i = ~clk_i;
   pmc_perf_monitor #(.SEC_CYCLES(SEC)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .events_i(events_i), .link_cfg_i(cfg), .irq_o(irq_o));
   pmc_event_source src (.clk_i(clk_i), .events_o(events_i));
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [11:0] ra(input logic [1:0] l, input logic [7:0] off);
      return {l, off, 2'b00};
   endfunction
   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
      int n = 0;
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= {24'h000000, d};
      @(posedge clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      if (pready_o !== 1'b1) begin
         error_cnt++;
         $display("MISMATCH apb answer expected 1 seen %b", pready_o);
      end
      rd = prdata_o[7:0];
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic grab(input logic [1:0] l, input logic [3:0] code);
      apb(1'b1, ra(2'b00, IDX_ACCESS_SELECT[7:0]), {2'b00, l, code});
      apb(1'b1, ra(l, IDX_UPDATE_CONTROL), 8'h00);
      apb(1'b1, ra(l, IDX_UPDATE_CONTROL), 8'h01);
      apb(1'b0, ra(2'b00, IDX_ACCESS_READBACK[7:0]), 8'h00);
   endtask
   task automatic t_reset();
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, ra(2'b11, IDX_UPDATE_CONTROL + 8'(i)), 8'h00);
         chk("reg reset", {7'h00, err, rd}, 16'h0000);
      end
      apb(1'b1, ra(2'b00, IDX_ACCESS_READBACK[7:0]), 8'h5A);
      apb(1'b0, ra(2'b00, IDX_ACCESS_READBACK[7:0]), 8'h00);
      chk("readback ro", {7'h00, err, rd}, 16'h0000);
      apb(1'b0, ra(2'b01, 8'hC7), 8'h00);
      chk("unmapped", {15'h0000, err}, 16'h0001);
      $display("t_reset done");
   endtask
   task automatic t_formats();
      logic [7:0] exp;
      for (int f = 0; f < 4; f++) begin
         cfg[2] <= '{format: pmc_format_e'(f), j1_mode: 1'b0};
         for (int c = 0; c < 7; c++) begin
            src.fire(2, bits[c], 3);
            grab(2'b10, codes[c]);
            exp = ((c == 0 && f != 1) || (c == 6 && f != 2)) ? 8'h00 : 8'h03;
            chk("format count", {8'h00, rd}, {8'h00, exp});
         end
      end
      cfg[2] <= '{format: PMC_FMT_DM, j1_mode: 1'b1};
      src.fire(2, 3, 2);
      grab(2'b10, SEL_DDS_LO);
      chk("dds j1", {8'h00, rd}, 16'h0000);
      for (int c = 0; c < 5; c++) begin
         cfg[1] <= '{format: (c == 4) ? PMC_FMT_DM : PMC_FMT_ESF, j1_mode: 1'b0};
         src.fire(1, hbits[c], 256);
         grab(2'b01, hcodes[c]);
         chk("high byte", {8'h00, rd}, 16'h0001);
      end
      $display("t_formats done");
   endtask
   task automatic t_clear();
      logic [7:0] first;
      src.fire(3, 6, 2);
      src.fire(0, 6, 4);
      grab(2'b00, SEL_LINE_CODE_LO);
      chk("manual copy", {8'h00, rd}, 16'h0004);
      grab(2'b00, SEL_LINE_CODE_LO);
      chk("group clear", {8'h00, rd}, 16'h0000);
      fork
         src.fire(0, 6, 40);
         grab(2'b00, SEL_LINE_CODE_LO);
      join
      first = rd;
      grab(2'b00, SEL_LINE_CODE_LO);
      chk("no lost event", {8'h00, first + rd}, 16'h0028);
      grab(2'b11, SEL_LINE_CODE_LO);
      chk("other link kept", {8'h00, rd}, 16'h0002);
      $display("t_clear done");
   endtask
   task automatic t_overflow();
      src.fire(0, 2, 9);
      apb(1'b0, ra(2'b00, IDX_FLAGS_LOW), 8'h00);
      chk("flag set", {8'h00, rd}, 16'h0010);
      @(negedge clk_i);
      chk("irq masked", {15'h0000, irq_o}, 16'h0000);
      apb(1'b1, ra(2'b00, IDX_IRQ_ENABLE_LOW), 8'h10);
      @(negedge clk_i);
      chk("irq on", {15'h0000, irq_o}, 16'h0001);
      grab(2'b00, SEL_POSITION);
      chk("saturate", {8'h00, rd}, 16'h0007);
      apb(1'b1, ra(2'b00, IDX_FLAGS_LOW), 8'h10);
      @(negedge clk_i);
      chk("irq cleared", {15'h0000, irq_o}, 16'h0000);
      $display("t_overflow done");
   endtask
   task automatic t_auto();
      logic seen = 1'b0;
      apb(1'b1, ra(2'b00, IDX_ACCESS_SELECT[7:0]), 8'h38);
      apb(1'b1, ra(2'b11, IDX_UPDATE_CONTROL), 8'h02);
      src.fire(3, 6, 1);
      repeat (10) begin
         apb(1'b0, ra(2'b00, IDX_ACCESS_READBACK[7:0]), 8'h00);
         if (rd === 8'h01) seen = 1'b1;
      end
      chk("auto copy", {15'h0000, seen}, 16'h0001);
      apb(1'b1, ra(2'b11, IDX_UPDATE_CONTROL), 8'h00);
      src.fire(3, 6, 2);
      repeat (2 * SEC) @(posedge clk_i);
      grab(2'b11, SEL_LINE_CODE_LO);
      chk("auto off", {8'h00, rd}, 16'h0002);
      $display("t_auto done");
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_reset();
      t_formats();
      t_clear();
      t_overflow();
      t_auto();
      test_done();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      test_done();
   end
endmodule
`default_nettype wire

// [verilog/pmc_perf_monitor.sv]
/*
 * T1/J1 performance monitor: per-link saturating event counters read
 * indirectly through an APB register window, with one-second or manual
 * transfer-and-clear and overflow flags gated onto a level interrupt.
 * Assumes event pulses and link configuration come from logic on clk_i.
 */
`default_nettype none
// Function
// - Overflow sets flag; interrupt only when enabled
// - Counters reachable only through indirect window
// - Selected counter byte copied to readback
// - Auto bit copies selected counter each second
// - Manual bit rising edge copies immediately
// - Transfer clears all counters of selected link
// - Events during transfer are never lost
// - Counted events depend on link framing format
// - Sixteen-bit line code violation counter
// - Twelve-bit framing error counter
// - CRC-6 counter active in ESF only
// - DDS counter active in T1 DM only
// - Three-bit frame position change counter
// - Five-bit sync loss counter
// - Sixteen-bit pattern receiver error counter
// - Fixed selection codes map counter bytes
module pmc_perf_monitor #(
   parameter int SEC_CYCLES = pmc_pkg::SECOND_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire pmc_pkg::pmc_event_s [pmc_pkg::NUM_LINKS-1:0] events_i,
   input wire pmc_pkg::pmc_link_cfg_s [pmc_pkg::NUM_LINKS-1:0] link_cfg_i,
   output logic irq_o
);
   import pmc_pkg::*;

   pmc_state_s q;
   pmc_state_s n;

   localparam logic [23:0] SEC_LAST = 24'(SEC_CYCLES - 1);

   // Saturating step; bit 16 marks an overflow attempt
   function automatic logic [16:0] pmc_step(input logic [15:0] v, input logic [15:0] mx,
                                            input logic ev, input logic clr);
      logic [16:0] r;
      r = {1'b0, v};
      if (clr) begin
         r = {16'h0000, ev};
      end else if (ev) begin
         if (v == mx) begin
            r = {1'b1, v};
         end else begin
            r = {1'b0, v + 16'h0001};
         end
      end
      return r;
   endfunction

   // Byte view of one counter by selection code
   function automatic logic [7:0] pmc_byte(input pmc_counters_s c, input logic [3:0] code);
      logic [7:0] b;
      b = 8'h00;
      case (code)
         SEL_CRC6_LO: b = c.crc6_error_count[7:0];
         SEL_CRC6_HI: b = {6'h00, c.crc6_error_count[9:8]};
         SEL_FRAMING_LO: b = c.framing_error_count[7:0];
         SEL_FRAMING_HI: b = {4'h0, c.framing_error_count[11:8]};
         SEL_POSITION: b = {5'h00, c.frame_position_change_count};
         SEL_SYNC_LOSS: b = {3'h0, c.sync_loss_count};
         SEL_PATTERN_LO: b = c.pattern_receiver_error_count[7:0];
         SEL_PATTERN_HI: b = c.pattern_receiver_error_count[15:8];
         SEL_LINE_CODE_LO: b = c.line_code_violation_count[7:0];
         SEL_LINE_CODE_HI: b = c.line_code_violation_count[15:8];
         SEL_DDS_LO: b = c.dds_pattern_error_count[7:0];
         SEL_DDS_HI: b = {6'h00, c.dds_pattern_error_count[9:8]};
         default: b = 8'h00;
      endcase
      return b;
   endfunction

   logic access;
   logic take;
   logic [9:0] idx;
   logic [1:0] reg_link;
   logic [7:0] reg_off;
   logic global_hit;
   logic link_hit;
   logic hit;
   logic [7:0] rd_byte;
   logic sec_tick;
   logic manual_rise;
   logic transfer;
   logic [NUM_LINKS-1:0] link_clear;
   logic [NUM_LINKS-1:0][NUM_OVF-1:0] ovf_set;
   logic [NUM_OVF-1:0] w1c;

   always_comb begin
      logic [16:0] t;
      logic crc_ev;
      logic dds_ev;
      t = 17'h00000;
      crc_ev = 1'b0;
      dds_ev = 1'b0;
      n = q;
      w1c = '0;

      // APB decode; one wait state so that read data comes from a flop
      access = psel_i & penable_i;
      take = access & q.ready;
      idx = paddr_i[11:2];
      reg_link = idx[9:8];
      reg_off = idx[7:0];
      global_hit = (idx == IDX_ACCESS_SELECT) || (idx == IDX_ACCESS_READBACK);
      link_hit = (reg_off >= IDX_UPDATE_CONTROL) && (reg_off <= IDX_FLAGS_HIGH);
      hit = global_hit | link_hit;

      rd_byte = RESET_BYTE;
      if (idx == IDX_ACCESS_SELECT) begin
         rd_byte = {2'b00, q.link_choice, q.cnt_choice};
      end else if (idx == IDX_ACCESS_READBACK) begin
         rd_byte = q.readback;
      end else begin
         case (reg_off)
            IDX_UPDATE_CONTROL:
               rd_byte = {6'h00, q.auto_transfer_bit[reg_link],
                          q.manual_transfer_bit[reg_link]};
            IDX_IRQ_ENABLE_LOW: rd_byte = {2'b00, q.ovf_irq_on[reg_link][5:0]};
            IDX_IRQ_ENABLE_HIGH: rd_byte = {7'h00, q.ovf_irq_on[reg_link][OVF_LINE_CODE]};
            IDX_FLAGS_LOW: rd_byte = {2'b00, q.ovf_flags[reg_link][5:0]};
            IDX_FLAGS_HIGH: rd_byte = {7'h00, q.ovf_flags[reg_link][OVF_LINE_CODE]};
            default: rd_byte = RESET_BYTE;
         endcase
      end

      if (access && !q.ready) begin
         n.ready = 1'b1;
         n.prdata = rd_byte;
         n.err = ~hit;
      end else begin
         n.ready = 1'b0;
         n.err = 1'b0;
      end

      // Free-running divider shared by all links
      sec_tick = (q.sec_cnt == SEC_LAST);
      n.sec_cnt = sec_tick ? 24'h000000 : q.sec_cnt + 24'h000001;

      manual_rise = 1'b0;
      if (take && pwrite_i && hit) begin
         if (idx == IDX_ACCESS_SELECT) begin
            n.link_choice = pwdata_i[SEL_LINK_LSB +: 2];
            n.cnt_choice = pwdata_i[SEL_CNT_LSB +: 4];
         end else if (!global_hit) begin
            case (reg_off)
               IDX_UPDATE_CONTROL: begin
                  // Any link's control write with a 0 to 1 step triggers
                  manual_rise = pwdata_i[CTRL_MANUAL_BIT]
                                & ~q.manual_transfer_bit[reg_link];
                  n.manual_transfer_bit[reg_link] = pwdata_i[CTRL_MANUAL_BIT];
                  n.auto_transfer_bit[reg_link] = pwdata_i[CTRL_AUTO_BIT];
               end
               IDX_IRQ_ENABLE_LOW: n.ovf_irq_on[reg_link][5:0] = pwdata_i[5:0];
               IDX_IRQ_ENABLE_HIGH: n.ovf_irq_on[reg_link][OVF_LINE_CODE] = pwdata_i[0];
               IDX_FLAGS_LOW: w1c[5:0] = pwdata_i[5:0];
               IDX_FLAGS_HIGH: w1c[OVF_LINE_CODE] = pwdata_i[0];
               default: w1c = '0;
            endcase
         end
      end

      // Manual works whatever the auto bit holds
      transfer = manual_rise
                 | (sec_tick & q.auto_transfer_bit[q.link_choice]);
      if (transfer) begin
         n.readback = pmc_byte(q.cnt[q.link_choice], q.cnt_choice);
      end

      for (int l = 0; l < NUM_LINKS; l++) begin
         link_clear[l] = transfer && (q.link_choice == 2'(l));
         crc_ev = events_i[l].crc6
                  & (link_cfg_i[l].format == PMC_FMT_ESF);
         dds_ev = events_i[l].dds & (link_cfg_i[l].format == PMC_FMT_DM)
                  & ~link_cfg_i[l].j1_mode;

         t = pmc_step(q.cnt[l].line_code_violation_count, LINE_CODE_MAX,
                      events_i[l].line_code, link_clear[l]);
         n.cnt[l].line_code_violation_count = t[15:0];
         ovf_set[l][OVF_LINE_CODE] = t[16];

         t = pmc_step(16'(q.cnt[l].framing_error_count), FRAMING_MAX,
                      events_i[l].framing, link_clear[l]);
         n.cnt[l].framing_error_count = t[11:0];
         ovf_set[l][OVF_FRAMING] = t[16];

         t = pmc_step(16'(q.cnt[l].crc6_error_count), CRC6_MAX, crc_ev, link_clear[l]);
         n.cnt[l].crc6_error_count = t[9:0];
         ovf_set[l][OVF_CRC6] = t[16];

         t = pmc_step(16'(q.cnt[l].dds_pattern_error_count), DDS_MAX, dds_ev, link_clear[l]);
         n.cnt[l].dds_pattern_error_count = t[9:0];
         ovf_set[l][OVF_DDS] = t[16];

         t = pmc_step(16'(q.cnt[l].frame_position_change_count), POSITION_MAX,
                      events_i[l].position, link_clear[l]);
         n.cnt[l].frame_position_change_count = t[2:0];
         ovf_set[l][OVF_POSITION] = t[16];

         t = pmc_step(16'(q.cnt[l].sync_loss_count), SYNC_LOSS_MAX,
                      events_i[l].sync_loss, link_clear[l]);
         n.cnt[l].sync_loss_count = t[4:0];
         ovf_set[l][OVF_SYNC_LOSS] = t[16];

         t = pmc_step(q.cnt[l].pattern_receiver_error_count, PATTERN_MAX,
                      events_i[l].pattern, link_clear[l]);
         n.cnt[l].pattern_receiver_error_count = t[15:0];
         ovf_set[l][OVF_PATTERN] = t[16];

         // Set wins over a simultaneous write-one clear
         if (take && pwrite_i && !global_hit && (reg_link == 2'(l))) begin
            n.ovf_flags[l] = (q.ovf_flags[l] & ~w1c) | ovf_set[l];
         end else begin
            n.ovf_flags[l] = q.ovf_flags[l] | ovf_set[l];
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign prdata_o = {24'h000000, q.prdata};
   assign pready_o = q.ready;
   assign pslverr_o = q.ready & q.err;
   assign irq_o = |(q.ovf_flags & q.ovf_irq_on);

endmodule
`default_nettype wire
